// >>> core/sda_pkg.sv
package sda_pkg;

  // ---------------------------------------------------------------
  // link word layout
  // ---------------------------------------------------------------
  localparam int unsigned WORD_W = 16;

  // control word bits
  localparam int unsigned CTL_BACKLIGHT_OFF = 0;
  localparam int unsigned CTL_BUZZER_ON     = 1;
  localparam int unsigned CTL_BUZZER_DIS    = 4;
  localparam int unsigned CTL_AUX_DIS       = 5;
  localparam int unsigned CTL_EXCLUSIVE     = 7;
  localparam int unsigned CTL_ENLARGED      = 8;
  localparam int unsigned CTL_HC_CANCEL     = 11;
  localparam logic [15:0] CTL_USED_MASK     = 16'h09B3;

  // screen word and print request word
  localparam int unsigned SCR_OFF           = 0;
  localparam int unsigned REQ_PRINT         = 2;

  // year word: most significant bit is the clock write flag
  localparam int unsigned YEAR_WRITE_FLAG   = 15;

  // status word bits
  localparam int unsigned STS_PRINTING      = 2;
  localparam int unsigned STS_BL_BURNOUT    = 5;
  localparam int unsigned STS_TOUCH_ERR     = 6;
  localparam int unsigned STS_KEY_TOGGLE    = 8;
  localparam int unsigned STS_EXCLUSIVE     = 9;
  localparam int unsigned STS_ALARM         = 10;

  localparam logic [15:0] WORD_RESET        = 16'h0000;

  // ---------------------------------------------------------------
  // controller register map (apb byte offsets)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_PRINT    = 8'h04;
  localparam logic [7:0] OFS_YEAR     = 8'h08;
  localparam logic [7:0] OFS_MONDATE  = 8'h0C;
  localparam logic [7:0] OFS_TIME     = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  localparam logic [7:0] OFS_SCREEN   = 8'h18;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned TOUCH_LIMIT_MS  = 5000;
  localparam int unsigned TOUCH_LIMIT_CYC = TOUCH_LIMIT_MS * (CLK_HZ / 1000);

endpackage

// >>> core/sda_link_if.sv
`timescale 1ns/1ps
interface sda_link_if;
  import sda_pkg::*;

  // controller to panel
  logic [WORD_W-1:0] ctl_word;
  logic [WORD_W-1:0] screen_word;
  logic [WORD_W-1:0] print_req_word;
  logic [WORD_W-1:0] year_word;
  logic [WORD_W-1:0] mondate_word;
  logic [WORD_W-1:0] time_word;
  // panel to controller
  logic [WORD_W-1:0] status_word;
  logic              enlarged_clr;

  modport panel (
    input  ctl_word, screen_word, print_req_word, year_word, mondate_word, time_word,
    output status_word, enlarged_clr
  );
  modport controller (
    output ctl_word, screen_word, print_req_word, year_word, mondate_word, time_word,
    input  status_word, enlarged_clr
  );
endinterface

// >>> core/sda_controller.sv
`timescale 1ns/1ps
module sda_controller
  import sda_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // link
  sda_link_if.controller   link
);

  // ---------------------------------------------------------------
  // apb handshake
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] ctl_ff;
  logic [WORD_W-1:0] screen_ff;
  logic [WORD_W-1:0] req_ff;
  logic [WORD_W-1:0] year_ff;
  logic [WORD_W-1:0] mondate_ff;
  logic [WORD_W-1:0] time_ff;
  logic [31:0]       prdata_ff;
  logic              pready_ff;
  logic              pslverr_ff;
  logic              mapped;
  logic              access;
  logic              wr;
  logic [WORD_W-1:0] nxt_rdata;

  // one wait state: answer lands on the second access cycle
  assign access = psel && penable && !pready_ff;
  assign wr     = access && pwrite && mapped;

  always_comb begin
    mapped    = 1'b1;
    nxt_rdata = WORD_RESET;
    unique case (paddr)
      OFS_CTRL:    nxt_rdata = ctl_ff;
      OFS_PRINT:   nxt_rdata = req_ff;
      OFS_YEAR:    nxt_rdata = year_ff;
      OFS_MONDATE: nxt_rdata = mondate_ff;
      OFS_TIME:    nxt_rdata = time_ff;
      OFS_STATUS:  nxt_rdata = link.status_word;
      OFS_SCREEN:  nxt_rdata = screen_ff;
      default:     mapped    = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= access;
      pslverr_ff <= access && !mapped;
      if (access && !pwrite) begin
        prdata_ff <= {16'h0000, nxt_rdata};
      end
    end
  end

  // ---------------------------------------------------------------
  // system data area words
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_ff <= WORD_RESET;
    end else if (wr && paddr == OFS_CTRL) begin
      // reserved bits always go out as zero
      ctl_ff <= pwdata[15:0] & CTL_USED_MASK;
    end else if (link.enlarged_clr) begin
      ctl_ff[CTL_ENLARGED] <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      screen_ff  <= WORD_RESET;
      req_ff     <= WORD_RESET;
      year_ff    <= WORD_RESET;
      mondate_ff <= WORD_RESET;
      time_ff    <= WORD_RESET;
    end else if (wr) begin
      unique case (paddr)
        OFS_SCREEN:  screen_ff  <= pwdata[15:0] & 16'h0001;
        // request only ever cleared by software
        OFS_PRINT:   req_ff     <= pwdata[15:0] & 16'h0004;
        OFS_YEAR:    year_ff    <= pwdata[15:0];
        OFS_MONDATE: mondate_ff <= pwdata[15:0];
        OFS_TIME:    time_ff    <= pwdata[15:0];
        default:     ;
      endcase
    end
  end

  assign prdata              = prdata_ff;
  assign pready              = pready_ff;
  assign pslverr             = pslverr_ff;
  assign link.ctl_word       = ctl_ff;
  assign link.screen_word    = screen_ff;
  assign link.print_req_word = req_ff;
  assign link.year_word      = year_ff;
  assign link.mondate_word   = mondate_ff;
  assign link.time_word      = time_ff;

endmodule

// >>> core/sda_panel.sv
`timescale 1ns/1ps
module sda_panel
  import sda_pkg::*;
#(
  parameter int unsigned TOUCH_LIMIT = TOUCH_LIMIT_CYC,
  parameter int unsigned POS_W       = 10
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // link
  sda_link_if.panel             link,
  // panel events
  input  wire logic             multi_drop,
  input  wire logic             lamp_fail,
  input  wire logic             touch_active,
  input  wire logic [POS_W-1:0] touch_x,
  input  wire logic [POS_W-1:0] touch_y,
  input  wire logic             touch_unused,
  input  wire logic             key_commit,
  input  wire logic             key_out_of_range,
  input  wire logic             screen_change,
  input  wire logic             print_done,
  // panel controls
  output logic                  backlight_on,
  output logic                  display_on,
  output logic                  buzzer,
  output logic                  aux_buzzer,
  output logic                  exclusive_grant,
  output logic                  enlarged_mode,
  output logic                  print_start,
  output logic                  print_cancel,
  output logic                  printing,
  output logic                  rtc_load,
  output logic [WORD_W-1:0]     rtc_year,
  output logic [WORD_W-1:0]     rtc_mondate,
  output logic [WORD_W-1:0]     rtc_time
);

  // ---------------------------------------------------------------
  // edge detection on controller levels
  // ---------------------------------------------------------------
  logic req_q_ff, wflag_q_ff, cancel_q_ff, scr_q_ff;
  logic req_rise, wflag_edge, cancel_rise, scr_rise, cancel_lvl;

  assign cancel_lvl  = link.ctl_word[CTL_HC_CANCEL];
  // only transitions act, so a held level never retriggers
  assign req_rise    = link.print_req_word[REQ_PRINT] && !req_q_ff;
  assign wflag_edge  = link.year_word[YEAR_WRITE_FLAG] != wflag_q_ff;
  assign cancel_rise = cancel_lvl && !cancel_q_ff;
  assign scr_rise    = link.screen_word[SCR_OFF] && !scr_q_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_q_ff    <= 1'b0;
      wflag_q_ff  <= 1'b0;
      cancel_q_ff <= 1'b0;
      scr_q_ff    <= 1'b0;
    end else begin
      req_q_ff    <= link.print_req_word[REQ_PRINT];
      wflag_q_ff  <= link.year_word[YEAR_WRITE_FLAG];
      cancel_q_ff <= cancel_lvl;
      scr_q_ff    <= link.screen_word[SCR_OFF];
    end
  end

  // ---------------------------------------------------------------
  // hard copy
  // ---------------------------------------------------------------
  logic printing_ff, print_start_ff, print_cancel_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      printing_ff     <= 1'b0;
      print_start_ff  <= 1'b0;
      print_cancel_ff <= 1'b0;
    end else begin
      // a set cancel bit refuses new hard copies
      print_start_ff  <= req_rise && !cancel_lvl && !printing_ff;
      print_cancel_ff <= cancel_rise && printing_ff;
      if (req_rise && !cancel_lvl && !printing_ff) begin
        printing_ff <= 1'b1;
      end else if (print_done) begin
        // done comes after the last image line; buffer kept
        printing_ff <= 1'b0;
      end
    end
  end
  // cancel bit and request word never cleared here

  // ---------------------------------------------------------------
  // real-time clock reload
  // ---------------------------------------------------------------
  logic              rtc_load_ff;
  logic [WORD_W-1:0] rtc_year_ff;
  logic [WORD_W-1:0] rtc_mondate_ff;
  logic [WORD_W-1:0] rtc_time_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rtc_load_ff    <= 1'b0;
      rtc_year_ff    <= WORD_RESET;
      rtc_mondate_ff <= WORD_RESET;
      rtc_time_ff    <= WORD_RESET;
    end else begin
      rtc_load_ff <= wflag_edge;
      if (wflag_edge) begin
        // flag bit is a commit marker, not part of the year
        rtc_year_ff    <= {1'b0, link.year_word[14:0]};
        rtc_mondate_ff <= link.mondate_word;
        rtc_time_ff    <= link.time_word;
      end
    end
  end

  // ---------------------------------------------------------------
  // touch hold watchdog
  // ---------------------------------------------------------------
  logic [POS_W-1:0] last_x_ff;
  logic [POS_W-1:0] last_y_ff;
  logic [31:0]      hold_cnt_ff;
  logic             touch_err_ff;
  logic             same_pos;

  assign same_pos = touch_x == last_x_ff && touch_y == last_y_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last_x_ff    <= '0;
      last_y_ff    <= '0;
      hold_cnt_ff  <= 32'h0000_0000;
      touch_err_ff <= 1'b0;
    end else begin
      last_x_ff <= touch_x;
      last_y_ff <= touch_y;
      if (!touch_active || !same_pos) begin
        hold_cnt_ff  <= 32'h0000_0000;
        touch_err_ff <= 1'b0;
      end else if (hold_cnt_ff < TOUCH_LIMIT) begin
        hold_cnt_ff <= hold_cnt_ff + 32'h0000_0001;
      end else begin
        touch_err_ff <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // keypad entry and alarm
  // ---------------------------------------------------------------
  logic key_toggle_ff;
  logic alarm_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      key_toggle_ff <= 1'b0;
    end else if (key_commit) begin
      key_toggle_ff <= !key_toggle_ff;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      alarm_ff <= 1'b0;
    end else if (key_commit && key_out_of_range) begin
      // a fresh violation wins over a screen change
      alarm_ff <= 1'b1;
    end else if (key_commit || screen_change) begin
      alarm_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // display, backlight, buzzer, exclusive, enlarged
  // ---------------------------------------------------------------
  logic display_on_ff, backlight_on_ff, buzzer_ff, aux_ff;
  logic excl_ff, enlarged_ff, enl_clr_ff, burnout_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      display_on_ff <= 1'b1;
    end else if (touch_active) begin
      display_on_ff <= 1'b1;
    end else if (scr_rise) begin
      display_on_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      backlight_on_ff <= 1'b1;
      buzzer_ff       <= 1'b0;
      aux_ff          <= 1'b0;
      excl_ff         <= 1'b0;
      enlarged_ff     <= 1'b0;
      enl_clr_ff      <= 1'b0;
      burnout_ff      <= 1'b0;
    end else begin
      // only the lamp; display and touch keep running
      backlight_on_ff <= !link.ctl_word[CTL_BACKLIGHT_OFF];
      buzzer_ff       <= link.ctl_word[CTL_BUZZER_ON] &&
                         !link.ctl_word[CTL_BUZZER_DIS];
      aux_ff          <= link.ctl_word[CTL_BUZZER_ON] &&
                         !link.ctl_word[CTL_AUX_DIS];
      excl_ff         <= multi_drop && link.ctl_word[CTL_EXCLUSIVE];
      enlarged_ff     <= link.ctl_word[CTL_ENLARGED] && !enl_clr_ff;
      // pulse asks the controller to drop the mode bit
      enl_clr_ff      <= link.ctl_word[CTL_ENLARGED] && touch_unused && !enl_clr_ff;
      burnout_ff      <= lamp_fail;
    end
  end

  // ---------------------------------------------------------------
  // status word and outputs
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] status_ff;

  // reserved status bits are driven zero; controller must not rely on it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_ff <= WORD_RESET;
    end else begin
      status_ff                 <= WORD_RESET;
      status_ff[STS_PRINTING]   <= printing_ff || (req_rise && !cancel_lvl);
      status_ff[STS_BL_BURNOUT] <= burnout_ff;
      status_ff[STS_TOUCH_ERR]  <= touch_err_ff;
      status_ff[STS_KEY_TOGGLE] <= key_toggle_ff;
      status_ff[STS_EXCLUSIVE]  <= excl_ff;
      status_ff[STS_ALARM]      <= alarm_ff;
    end
  end

  assign link.status_word  = status_ff;
  assign link.enlarged_clr = enl_clr_ff;
  assign backlight_on      = backlight_on_ff;
  assign display_on        = display_on_ff;
  assign buzzer            = buzzer_ff;
  assign aux_buzzer        = aux_ff;
  assign exclusive_grant   = excl_ff;
  assign enlarged_mode     = enlarged_ff;
  assign print_start       = print_start_ff;
  assign print_cancel      = print_cancel_ff;
  assign printing          = printing_ff;
  assign rtc_load          = rtc_load_ff;
  assign rtc_year          = rtc_year_ff;
  assign rtc_mondate       = rtc_mondate_ff;
  assign rtc_time          = rtc_time_ff;

endmodule

// >>> verification/sda_link_props.sv
`timescale 1ns/1ps
module sda_link_props
  import sda_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              reset_n,
  // link words
  input wire logic [WORD_W-1:0] ctl_word,
  input wire logic [WORD_W-1:0] print_req_word,
  input wire logic [WORD_W-1:0] status_word,
  input wire logic              enlarged_clr
);
  // ----------------------------------------
  // link protocol checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_print_start;
    $rose(print_req_word[REQ_PRINT]) && !ctl_word[CTL_HC_CANCEL] && !status_word[STS_PRINTING]
      |-> ##[1:3] status_word[STS_PRINTING];
  endproperty
  a_print_start: assert property (p_print_start) else $error("print request not honoured");

  property p_req_kept;
    $fell(status_word[STS_PRINTING]) |-> print_req_word[REQ_PRINT];
  endproperty
  a_req_kept: assert property (p_req_kept) else $error("request gone at print end");

  // four samples of a held request cannot start a second print
  property p_no_retrig;
    print_req_word[REQ_PRINT] && $past(print_req_word[REQ_PRINT])
      && $past(print_req_word[REQ_PRINT], 2) && $past(print_req_word[REQ_PRINT], 3)
      && !status_word[STS_PRINTING] |=> !status_word[STS_PRINTING];
  endproperty
  a_no_retrig: assert property (p_no_retrig) else $error("held request retriggered");

  property p_cancel_block;
    ctl_word[CTL_HC_CANCEL] && $rose(print_req_word[REQ_PRINT]) && !status_word[STS_PRINTING]
      |=> !status_word[STS_PRINTING] [*3];
  endproperty
  a_cancel_block: assert property (p_cancel_block) else $error("print ran while blocked");

  property p_cancel_stays;
    ctl_word[CTL_HC_CANCEL] && status_word[STS_PRINTING] |=> ctl_word[CTL_HC_CANCEL];
  endproperty
  a_cancel_stays: assert property (p_cancel_stays) else $error("cancel bit dropped");

  property p_enl_clr;
    enlarged_clr |-> ctl_word[CTL_ENLARGED] ##1 !ctl_word[CTL_ENLARGED];
  endproperty
  a_enl_clr: assert property (p_enl_clr) else $error("enlarged bit not cleared");

  property p_enl_pulse;
    enlarged_clr |=> !enlarged_clr;
  endproperty
  a_enl_pulse: assert property (p_enl_pulse) else $error("enlarged clear too long");

  property p_ctl_reserved;
    (ctl_word & ~CTL_USED_MASK) == 16'h0000;
  endproperty
  a_ctl_reserved: assert property (p_ctl_reserved) else $error("reserved control bit set");

  property p_sts_reserved;
    (status_word & ~16'h0764) == 16'h0000;
  endproperty
  a_sts_reserved: assert property (p_sts_reserved) else $error("reserved status bit set");

  property p_excl;
    status_word[STS_EXCLUSIVE] |-> $past(ctl_word[CTL_EXCLUSIVE]) || $past(ctl_word[CTL_EXCLUSIVE], 2);
  endproperty
  a_excl: assert property (p_excl) else $error("exclusive status without control");
endmodule

// >>> verification/tb.sv
`timescale 1ns/1ps
module tb;
  import sda_pkg::*;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        md, lamp, tact, tun, kc, koor, scr, pdone;
  logic [9:0]  tx, ty;
  logic        bl_on, disp_on, buz, aux, excl, enl, pstart, pcancel, printing, load;
  logic [15:0] ryear, rmd, rtime;
  int          error_cnt, comparisons, n_start, n_cancel, n_load;
  logic [15:0] cv [4] = '{16'h0002, 16'h0012, 16'h0022, 16'h0001};
  logic [2:0]  ev [4] = '{3'h7, 3'h5, 3'h6, 3'h0};

  sda_link_if link ();
  sda_controller u_sda_controller (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  // short touch limit keeps the stuck-touch case quick
  sda_panel #(.TOUCH_LIMIT(8)) u_sda_panel (.clk(clk), .reset_n(reset_n), .link(link),
    .multi_drop(md), .lamp_fail(lamp), .touch_active(tact), .touch_x(tx), .touch_y(ty),
    .touch_unused(tun), .key_commit(kc), .key_out_of_range(koor), .screen_change(scr),
    .print_done(pdone), .backlight_on(bl_on), .display_on(disp_on), .buzzer(buz),
    .aux_buzzer(aux), .exclusive_grant(excl), .enlarged_mode(enl), .print_start(pstart),
    .print_cancel(pcancel), .printing(printing), .rtc_load(load), .rtc_year(ryear),
    .rtc_mondate(rmd), .rtc_time(rtime));
  sda_link_props u_sda_link_props (.clk(clk), .reset_n(reset_n), .ctl_word(link.ctl_word),
    .print_req_word(link.print_req_word), .status_word(link.status_word),
    .enlarged_clr(link.enlarged_clr));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    // no cycle count assumed; only the watchdog ends a lost answer
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'h1, a, d, r, e);
    chk_bit(e, xe);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'h0, a, 32'h0, r, e);
    chk_word(r, x);
    chk_bit(e, xe);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic key(input logic oor);
    @(posedge clk);
    kc <= 1'h1;
    koor <= oor;
    @(posedge clk);
    kc <= 1'h0;
  endtask
  task automatic done_pulse;
    @(posedge clk);
    pdone <= 1'h1;
    @(posedge clk);
    pdone <= 1'h0;
    tick(3);
  endtask

  always @(posedge clk) begin
    if (pstart === 1'h1) n_start++;
    if (pcancel === 1'h1) n_cancel++;
    if (load === 1'h1) n_load++;
  end

  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {md, lamp, tact, tun, kc, koor, scr, pdone, tx, ty} = '0;
    repeat (8) @(posedge clk);
    reset_n <= 1'h1;
    chk_word({30'h0, bl_on, disp_on}, 32'h3);
    rd(OFS_CTRL, 32'h0, 1'h0);
    rd(OFS_STATUS, 32'h0, 1'h0);
    $display("test reset done");
    wr(OFS_CTRL, 32'hFFFF_FFFF, 1'h0);
    rd(OFS_CTRL, 32'h0000_09B3, 1'h0);
    tick(2);
    chk_word({27'h0, bl_on, disp_on, buz, aux, enl}, 32'h9);
    chk_bit(excl, 1'h0);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CTRL, {16'h0, cv[i]}, 1'h0);
      tick(2);
      chk_word({29'h0, bl_on, buz, aux}, {29'h0, ev[i]});
    end
    wr(8'h40, 32'h1234, 1'h1);
    rd(8'h40, 32'h0, 1'h1);
    $display("test control done");
    md <= 1'h1;
    lamp <= 1'h1;
    wr(OFS_CTRL, 32'h80, 1'h0);
    tick(2);
    chk_bit(excl, 1'h1);
    rd(OFS_STATUS, 32'h0220, 1'h0);
    tact <= 1'h1;
    tx <= 10'h5;
    ty <= 10'h7;
    tick(12);
    rd(OFS_STATUS, 32'h0260, 1'h0);
    tx <= 10'h6;
    tick(1);
    rd(OFS_STATUS, 32'h0220, 1'h0);
    tact <= 1'h0;
    key(1'h1);
    rd(OFS_STATUS, 32'h0720, 1'h0);
    key(1'h0);
    rd(OFS_STATUS, 32'h0220, 1'h0);
    key(1'h1);
    @(posedge clk);
    scr <= 1'h1;
    @(posedge clk);
    scr <= 1'h0;
    rd(OFS_STATUS, 32'h0320, 1'h0);
    md <= 1'h0;
    lamp <= 1'h0;
    wr(OFS_CTRL, 32'h0, 1'h0);
    rd(OFS_STATUS, 32'h0100, 1'h0);
    $display("test status done");
    wr(OFS_SCREEN, 32'h1, 1'h0);
    tick(2);
    chk_word({30'h0, disp_on, bl_on}, 32'h1);
    @(posedge clk);
    tact <= 1'h1;
    @(posedge clk);
    tact <= 1'h0;
    tick(2);
    chk_bit(disp_on, 1'h1);
    wr(OFS_SCREEN, 32'h0, 1'h0);
    wr(OFS_CTRL, 32'h100, 1'h0);
    tick(2);
    chk_bit(enl, 1'h1);
    @(posedge clk);
    tact <= 1'h1;
    tun <= 1'h1;
    @(posedge clk);
    tact <= 1'h0;
    tun <= 1'h0;
    tick(3);
    chk_bit(enl, 1'h0);
    rd(OFS_CTRL, 32'h0, 1'h0);
    $display("test screen done");
    wr(OFS_PRINT, 32'h4, 1'h0);
    tick(2);
    chk_bit(printing, 1'h1);
    rd(OFS_STATUS, 32'h0104, 1'h0);
    chk_word(n_start, 32'h1);
    done_pulse();
    chk_bit(printing, 1'h0);
    rd(OFS_STATUS, 32'h0100, 1'h0);
    rd(OFS_PRINT, 32'h4, 1'h0);
    tick(4);
    chk_word(n_start, 32'h1);
    wr(OFS_PRINT, 32'h0, 1'h0);
    wr(OFS_PRINT, 32'h4, 1'h0);
    tick(2);
    wr(OFS_CTRL, 32'h800, 1'h0);
    tick(2);
    chk_word({n_cancel[30:0], printing}, 32'h3);
    done_pulse();
    chk_bit(printing, 1'h0);
    rd(OFS_CTRL, 32'h800, 1'h0);
    wr(OFS_PRINT, 32'h0, 1'h0);
    wr(OFS_PRINT, 32'h4, 1'h0);
    tick(3);
    chk_word({n_start[30:0], printing}, 32'h4);
    wr(OFS_CTRL, 32'h0, 1'h0);
    wr(OFS_PRINT, 32'h0, 1'h0);
    $display("test print done");
    wr(OFS_MONDATE, 32'h1016, 1'h0);
    wr(OFS_TIME, 32'h2157, 1'h0);
    wr(OFS_YEAR, 32'h8095, 1'h0);
    tick(2);
    chk_word(n_load, 32'h1);
    chk_word({ryear, rmd}, 32'h0095_1016);
    chk_word({16'h0, rtime}, 32'h2157);
    wr(OFS_TIME, 32'h2200, 1'h0);
    tick(2);
    chk_word(n_load, 32'h1);
    wr(OFS_YEAR, 32'h0095, 1'h0);
    tick(2);
    chk_word({n_load[15:0], rtime}, 32'h0002_2200);
    $display("test clock done");
    give_verdict();
  end
endmodule
